/* File: rtl/fpm_pkg.sv */
// package with register map, field layouts, timing constants and enums of the front panel block
package fpm_pkg;
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned LONG_PRESS_MS = 500;
  localparam int unsigned UNLOCK_MS = 2000;
  localparam int unsigned IDLE_S = 90;
  localparam int unsigned DEBOUNCE_US = 5000;
  localparam int unsigned TICK_HZ = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int unsigned LONG_PRESS_TICKS = LONG_PRESS_MS * TICK_HZ / 1000;
  localparam int unsigned UNLOCK_TICKS = UNLOCK_MS * TICK_HZ / 1000;
  localparam int unsigned IDLE_TICKS = IDLE_S * TICK_HZ;
  localparam int unsigned DEBOUNCE_TICKS = DEBOUNCE_US * TICK_HZ / 1000000;
  localparam int unsigned NUM_KEYS = 4;
  localparam int unsigned NUM_ACTIONS = 17;
  localparam int unsigned NUM_PAGES = 4;
  localparam int unsigned NUM_LINES = 8;
  localparam logic [7:0] PHONES_CHAN = 8'h78;
  localparam logic [7:0] MAIN_CHAN_DEF = 8'h12;
  localparam logic [7:0] VOL_DEF = 8'h00;
  localparam logic [2:0] CURSOR_LINE_OPEN = 3'h1;
  localparam int unsigned KEY_OPTIONS = 3;

  // register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_REMAP = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_VOLUME = 12'h00c;
  localparam logic [11:0] ADDR_ACTION = 12'h010;

  // control register fields
  localparam int unsigned CTRL_LOCK_LSB = 0;
  localparam int unsigned CTRL_REMAP_BIT = 2;
  localparam int unsigned CTRL_SCOPE_BIT = 3;
  localparam int unsigned CTRL_SENSE_BIT = 4;
  localparam int unsigned CTRL_MAINCH_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_1200;
  localparam logic [31:0] CTRL_MASK = 32'h0000_ff1f;
  localparam logic [31:0] REMAP_MASK = 32'h1f1f_1f1f;

  typedef enum logic [1:0] {
    LOCK_OFF = 2'b00,
    LOCK_KEYS = 2'b01,
    LOCK_ALL = 2'b10
  } fpm_lock_type;

  typedef enum logic [2:0] {
    SCR_GLOBAL = 3'b000,
    SCR_ANALOG = 3'b001,
    SCR_VOLUME = 3'b010,
    SCR_OPTIONS = 3'b011,
    SCR_KEYMENU = 3'b100
  } fpm_screen_type;

  // action codes 0..16 for remapped keys
  typedef enum logic [4:0] {
    ACT_METER = 5'h00,
    ACT_SETUP1 = 5'h01,
    ACT_SETUP6 = 5'h06,
    ACT_ATTEN = 5'h07,
    ACT_RECALL = 5'h08,
    ACT_MUTE_EN = 5'h09,
    ACT_MAIN_MONO = 5'h0a,
    ACT_MAIN_MUTE = 5'h0b,
    ACT_MAIN_EQ = 5'h0c,
    ACT_MAIN_LOWCUT = 5'h0d,
    ACT_PH_MUTE = 5'h0e,
    ACT_PH_EQ = 5'h0f,
    ACT_PH_LOWCUT = 5'h10
  } fpm_action_type;
endpackage

/* File: rtl/fpm_front_panel.sv */
// front panel menu controller with debounce, encoder decode, timers and apb registers
`timescale 1ns/1ps
// How it works
// - meter view by default after reset and whenever no menu or volume screen is open
// - half-second knob press on meter view swaps between global and analog-only meter
// - turning knob on a meter view opens the selected output volume screen
// - short knob press outside menus toggles main and phones volume target
// - phones fixed on 7/8, main defaults to rear outputs, title shows the pair of the selected target
// - volume target and its value are always presented on the status outputs
// - knob press in a menu toggles adjust/horizontal and vertical cursor modes
// - options key opens options, cursor on line two, adjust mode
// - horizontal turns on line two cycle four option pages in order
// - two options presses inside a menu leave straight to meter view
// - ninety seconds without input in a menu returns to global meter
// - lockout off, keys, all; holding options two seconds clears it
// - remap off or on; each key picks one of seventeen actions
// - action codes cover meter, setups 1-6, attenuate, recall, mutes, eq, low cut
// - a remapped key held half a second opens its original menu instead
// - meter scope setting acts like the half-second knob press
// - rotation sense setting reverses the decoded encoder direction
// - midi input and output activity indicators for the meter side panel
module fpm_front_panel
  import fpm_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES,
  parameter int unsigned IDLE_T = IDLE_TICKS,
  parameter int unsigned DEB_T = DEBOUNCE_TICKS
) (
  input wire logic I_MCLK,
  input wire logic I_RESETN,
  input wire logic I_CE,
  input wire logic [3:0] I_KEY,
  input wire logic I_KNOB_PUSH,
  input wire logic I_ENC_A,
  input wire logic I_ENC_B,
  input wire logic I_MIDI_IN_ACT,
  input wire logic I_MIDI_OUT_ACT,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic [2:0] O_SCREEN,
  output logic [1:0] O_PAGE,
  output logic [2:0] O_LINE,
  output logic O_VERT_MODE,
  output logic O_VOL_PHONES,
  output logic [7:0] O_VOLUME,
  output logic [7:0] O_TITLE_CHAN,
  output logic O_SCOPE_MAIN,
  output logic O_MIDI_IN_LED,
  output logic O_MIDI_OUT_LED,
  output logic O_ACTION_STB,
  output logic [4:0] O_ACTION,
  output logic O_ADJ_STB,
  output logic O_ADJ_UP
);
  localparam int unsigned NIN = NUM_KEYS + 3;
  localparam logic [31:0] ONE = 32'h0000_0001;

  // ==========================================================
  // timebase and debounce
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] deb_r, deb_nxt;
  logic [NIN-1:0] deb_d_r;
  logic [7:0] deb_cnt_r [NIN];
  logic [7:0] deb_cnt_nxt [NIN];

  assign raw = {I_ENC_B, I_ENC_A, I_KNOB_PUSH, I_KEY};

  always_comb begin
    tick_nxt = 1'b0;
    tick_cnt_nxt = tick_cnt_r + ONE;
    if (tick_cnt_r >= TICK_CYC - 1) begin
      tick_cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
    deb_nxt = deb_r;
    for (int i = 0; i < NIN; i++) begin
      deb_cnt_nxt[i] = deb_cnt_r[i];
      if (raw[i] == deb_r[i]) begin
        deb_cnt_nxt[i] = '0;
      end else if (tick_r) begin
        if (32'(deb_cnt_r[i]) >= DEB_T) begin
          deb_nxt[i] = raw[i];
          deb_cnt_nxt[i] = '0;
        end else begin
          deb_cnt_nxt[i] = deb_cnt_r[i] + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
      deb_r <= '0;
      deb_d_r <= '0;
      for (int i = 0; i < NIN; i++) begin
        deb_cnt_r[i] <= '0;
      end
    end else if (I_CE) begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
      deb_r <= deb_nxt;
      deb_d_r <= deb_r;
      for (int i = 0; i < NIN; i++) begin
        deb_cnt_r[i] <= deb_cnt_nxt[i];
      end
    end
  end

  // ==========================================================
  // encoder decode: one step per detent on rising edge of a
  logic enc_step, enc_cw, step_up;
  logic [3:0] key_rise, key_fall;
  logic push_rise, push_fall;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] remap_r, remap_nxt;

  assign enc_step = deb_r[NUM_KEYS+1] & ~deb_d_r[NUM_KEYS+1];
  assign enc_cw = ~deb_r[NUM_KEYS+2];
  assign step_up = enc_cw ^ ctrl_r[CTRL_SENSE_BIT];
  assign key_rise = deb_r[3:0] & ~deb_d_r[3:0];
  assign key_fall = ~deb_r[3:0] & deb_d_r[3:0];
  assign push_rise = deb_r[NUM_KEYS] & ~deb_d_r[NUM_KEYS];
  assign push_fall = ~deb_r[NUM_KEYS] & deb_d_r[NUM_KEYS];

  // ==========================================================
  // menu state machine
  fpm_screen_type scr_r, scr_nxt, meter_r, meter_nxt;
  logic [1:0] page_r, page_nxt;
  logic [2:0] line_r, line_nxt;
  logic vert_r, vert_nxt;
  logic phones_r, phones_nxt;
  logic [7:0] vol_main_r, vol_main_nxt, vol_ph_r, vol_ph_nxt;
  logic opt_once_r, opt_once_nxt;
  logic [31:0] idle_r, idle_nxt;
  logic [15:0] push_hold_r, push_hold_nxt;
  logic push_long_r, push_long_nxt;
  logic [15:0] key_hold_r [NUM_KEYS];
  logic [15:0] key_hold_nxt [NUM_KEYS];
  logic [3:0] key_long_r, key_long_nxt;
  logic act_stb_r, act_stb_nxt;
  logic [4:0] act_r, act_nxt;
  logic adj_stb_r, adj_stb_nxt, adj_up_r, adj_up_nxt;
  logic lock_clear;
  logic scope_wr;
  logic any_in;
  logic in_menu;
  logic keys_locked, all_locked;

  assign in_menu = (scr_r == SCR_OPTIONS) || (scr_r == SCR_KEYMENU);
  assign keys_locked = ctrl_r[CTRL_LOCK_LSB +: 2] != LOCK_OFF;
  assign all_locked = ctrl_r[CTRL_LOCK_LSB +: 2] == LOCK_ALL;
  assign any_in = |key_rise | push_rise | enc_step;

  always_comb begin
    scr_nxt = scr_r;
    meter_nxt = meter_r;
    page_nxt = page_r;
    line_nxt = line_r;
    vert_nxt = vert_r;
    phones_nxt = phones_r;
    vol_main_nxt = vol_main_r;
    vol_ph_nxt = vol_ph_r;
    opt_once_nxt = opt_once_r;
    idle_nxt = idle_r;
    push_hold_nxt = push_hold_r;
    push_long_nxt = push_long_r;
    key_long_nxt = key_long_r;
    act_stb_nxt = 1'b0;
    act_nxt = act_r;
    adj_stb_nxt = 1'b0;
    adj_up_nxt = adj_up_r;
    lock_clear = 1'b0;
    for (int k = 0; k < NUM_KEYS; k++) begin
      key_hold_nxt[k] = key_hold_r[k];
      if (!deb_r[k]) begin
        key_hold_nxt[k] = '0;
      end else if (tick_r && key_hold_r[k] != 16'hffff) begin
        key_hold_nxt[k] = key_hold_r[k] + 16'h0001;
      end
    end
    if (!deb_r[NUM_KEYS]) begin
      push_hold_nxt = '0;
    end else if (tick_r && push_hold_r != 16'hffff) begin
      push_hold_nxt = push_hold_r + 16'h0001;
    end
    // idle timeout only runs while a menu is open
    if (!in_menu || any_in) begin
      idle_nxt = '0;
    end else if (tick_r) begin
      idle_nxt = idle_r + ONE;
    end
    if (in_menu && idle_r >= IDLE_T) begin
      scr_nxt = meter_r;
      meter_nxt = SCR_GLOBAL;
      scr_nxt = SCR_GLOBAL;
      opt_once_nxt = 1'b0;
    end
    // unlock by holding the options key
    if (keys_locked && 32'(key_hold_r[KEY_OPTIONS]) >= UNLOCK_TICKS) begin
      lock_clear = 1'b1;
    end
    // long knob press on meter view swaps meter scope
    if (!all_locked && deb_r[NUM_KEYS] && !push_long_r &&
        32'(push_hold_r) >= LONG_PRESS_TICKS) begin
      push_long_nxt = 1'b1;
      if (!in_menu) begin
        meter_nxt = (meter_r == SCR_GLOBAL) ? SCR_ANALOG : SCR_GLOBAL;
        scr_nxt = meter_nxt;
      end
    end
    if (push_fall) begin
      push_long_nxt = 1'b0;
      if (!all_locked && !push_long_r) begin
        if (in_menu) begin
          vert_nxt = ~vert_r;
        end else begin
          phones_nxt = ~phones_r;
        end
      end
    end
    if (scope_wr) begin
      meter_nxt = I_PWDATA[CTRL_SCOPE_BIT] ? SCR_ANALOG : SCR_GLOBAL;
      if (!in_menu) begin
        scr_nxt = meter_nxt;
      end
    end
    if (enc_step && !all_locked) begin
      if (!in_menu) begin
        scr_nxt = SCR_VOLUME;
        if (phones_r) begin
          vol_ph_nxt = step_up ? vol_ph_r + 8'h01 : vol_ph_r - 8'h01;
        end else begin
          vol_main_nxt = step_up ? vol_main_r + 8'h01 : vol_main_r - 8'h01;
        end
      end else if (vert_r) begin
        line_nxt = step_up ? line_r - 3'h1 : line_r + 3'h1;
      end else if (line_r == CURSOR_LINE_OPEN && scr_r == SCR_OPTIONS) begin
        page_nxt = step_up ? page_r + 2'h1 : page_r - 2'h1;
      end else begin
        adj_stb_nxt = 1'b1;
        adj_up_nxt = step_up;
      end
    end
    // key handling: long hold opens the native menu when remapped
    for (int k = 0; k < NUM_KEYS; k++) begin
      if (key_fall[k]) begin
        key_long_nxt[k] = 1'b0;
      end
      if (ctrl_r[CTRL_REMAP_BIT] && !keys_locked && deb_r[k] && !key_long_r[k] &&
          32'(key_hold_r[k]) >= LONG_PRESS_TICKS) begin
        key_long_nxt[k] = 1'b1;
        scr_nxt = (k == KEY_OPTIONS) ? SCR_OPTIONS : SCR_KEYMENU;
        line_nxt = CURSOR_LINE_OPEN;
        vert_nxt = 1'b0;
        page_nxt = '0;
      end
      if (ctrl_r[CTRL_REMAP_BIT] && !keys_locked && key_fall[k] && !key_long_r[k]) begin
        act_stb_nxt = 1'b1;
        act_nxt = remap_r[8*k +: 5];
      end
    end
    if (!ctrl_r[CTRL_REMAP_BIT] && !keys_locked && key_rise[KEY_OPTIONS]) begin
      if (in_menu && opt_once_r) begin
        scr_nxt = SCR_GLOBAL;
        meter_nxt = SCR_GLOBAL;
        opt_once_nxt = 1'b0;
      end else begin
        scr_nxt = SCR_OPTIONS;
        line_nxt = CURSOR_LINE_OPEN;
        vert_nxt = 1'b0;
        page_nxt = '0;
        opt_once_nxt = 1'b1;
      end
    end
    for (int k = 0; k < KEY_OPTIONS; k++) begin
      if (!ctrl_r[CTRL_REMAP_BIT] && !keys_locked && key_rise[k]) begin
        scr_nxt = SCR_KEYMENU;
        line_nxt = CURSOR_LINE_OPEN;
        vert_nxt = 1'b0;
        opt_once_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      scr_r <= SCR_GLOBAL;
      meter_r <= SCR_GLOBAL;
      page_r <= '0;
      line_r <= '0;
      vert_r <= 1'b0;
      phones_r <= 1'b0;
      vol_main_r <= VOL_DEF;
      vol_ph_r <= VOL_DEF;
      opt_once_r <= 1'b0;
      idle_r <= '0;
      push_hold_r <= '0;
      push_long_r <= 1'b0;
      key_long_r <= '0;
      act_stb_r <= 1'b0;
      act_r <= ACT_METER;
      adj_stb_r <= 1'b0;
      adj_up_r <= 1'b0;
      for (int k = 0; k < NUM_KEYS; k++) begin
        key_hold_r[k] <= '0;
      end
    end else if (I_CE) begin
      scr_r <= scr_nxt;
      meter_r <= meter_nxt;
      page_r <= page_nxt;
      line_r <= line_nxt;
      vert_r <= vert_nxt;
      phones_r <= phones_nxt;
      vol_main_r <= vol_main_nxt;
      vol_ph_r <= vol_ph_nxt;
      opt_once_r <= opt_once_nxt;
      idle_r <= idle_nxt;
      push_hold_r <= push_hold_nxt;
      push_long_r <= push_long_nxt;
      key_long_r <= key_long_nxt;
      act_stb_r <= act_stb_nxt;
      act_r <= act_nxt;
      adj_stb_r <= adj_stb_nxt;
      adj_up_r <= adj_up_nxt;
      for (int k = 0; k < NUM_KEYS; k++) begin
        key_hold_r[k] <= key_hold_nxt[k];
      end
    end
  end

  // ==========================================================
  // apb registers, one wait state per access
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic acc;

  assign acc = I_PSEL && I_PENABLE && !pready_r;
  assign scope_wr = acc && I_PWRITE && I_PADDR == ADDR_CTRL;

  always_comb begin
    ctrl_nxt = ctrl_r;
    remap_nxt = remap_r;
    prdata_nxt = prdata_r;
    pready_nxt = acc;
    pslverr_nxt = 1'b0;
    if (acc) begin
      unique case (I_PADDR)
        ADDR_CTRL: begin
          prdata_nxt = ctrl_r;
          if (I_PWRITE) begin
            ctrl_nxt = I_PWDATA & CTRL_MASK;
          end
        end
        ADDR_REMAP: begin
          prdata_nxt = remap_r;
          if (I_PWRITE) begin
            remap_nxt = I_PWDATA & REMAP_MASK;
          end
        end
        ADDR_STATUS: begin
          prdata_nxt = {19'h0, page_r, line_r, vert_r, phones_r, 3'h0, scr_r};
          pslverr_nxt = I_PWRITE;
        end
        ADDR_VOLUME: begin
          prdata_nxt = {16'h0, vol_ph_r, vol_main_r};
          pslverr_nxt = I_PWRITE;
        end
        ADDR_ACTION: begin
          prdata_nxt = {27'h0, act_r};
          pslverr_nxt = I_PWRITE;
        end
        default: begin
          prdata_nxt = '0;
          pslverr_nxt = 1'b1;
        end
      endcase
    end
    if (lock_clear) begin
      ctrl_nxt[CTRL_LOCK_LSB +: 2] = LOCK_OFF;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ctrl_r <= CTRL_RESET;
      remap_r <= '0;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (I_CE) begin
      ctrl_r <= ctrl_nxt;
      remap_r <= remap_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ==========================================================
  // registered display outputs
  logic [7:0] vol_r, title_r;
  logic midi_in_r, midi_out_r;
  logic scope_r;

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      scope_r <= 1'b0;
      vol_r <= VOL_DEF;
      title_r <= MAIN_CHAN_DEF;
      midi_in_r <= 1'b0;
      midi_out_r <= 1'b0;
    end else if (I_CE) begin
      scope_r <= (meter_nxt == SCR_ANALOG);
      vol_r <= phones_nxt ? vol_ph_nxt : vol_main_nxt;
      title_r <= phones_nxt ? PHONES_CHAN : ctrl_r[CTRL_MAINCH_LSB +: 8];
      midi_in_r <= I_MIDI_IN_ACT;
      midi_out_r <= I_MIDI_OUT_ACT;
    end
  end

  assign O_PRDATA = prdata_r;
  assign O_PREADY = pready_r;
  assign O_PSLVERR = pslverr_r;
  assign O_SCREEN = scr_r;
  assign O_PAGE = page_r;
  assign O_LINE = line_r;
  assign O_VERT_MODE = vert_r;
  assign O_VOL_PHONES = phones_r;
  assign O_VOLUME = vol_r;
  assign O_TITLE_CHAN = title_r;
  assign O_SCOPE_MAIN = scope_r;
  assign O_MIDI_IN_LED = midi_in_r;
  assign O_MIDI_OUT_LED = midi_out_r;
  assign O_ACTION_STB = act_stb_r;
  assign O_ACTION = act_r;
  assign O_ADJ_STB = adj_stb_r;
  assign O_ADJ_UP = adj_up_r;
endmodule

/* File: tb/fpm_operator.sv */
// operator model driving the keys, the knob push and the quadrature encoder
`timescale 1ns/1ps
module fpm_operator (
  input wire logic i_clk,
  output logic [3:0] o_key,
  output logic o_push,
  output logic o_enc_a,
  output logic o_enc_b
);
  logic [4:0] btn_r = 5'h00;
  assign o_key = btn_r[3:0];
  assign o_push = btn_r[4];
  initial begin
    o_enc_a = 1'b0;
    o_enc_b = 1'b0;
  end

  // ==========================================
  // buttons: index 4 is the knob push
  task automatic press(input int k, input int n);
    @(posedge i_clk);
    btn_r[k] <= 1'b1;
    repeat (n) @(posedge i_clk);
    btn_r[k] <= 1'b0;
    repeat (12) @(posedge i_clk);
  endtask

  // ==========================================
  // one detent, each phase held well past the contact filter
  task automatic turn(input logic cw);
    logic [7:0] s;
    s = cw ? 8'b10_11_01_00 : 8'b01_11_10_00;
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clk);
      {o_enc_a, o_enc_b} <= s[7-2*i -: 2];
      repeat (11) @(posedge i_clk);
    end
  endtask
endmodule

/* File: tb/fpm_front_panel_properties.sv */
// concurrent checks on the front panel top-level ports
`timescale 1ns/1ps
module fpm_front_panel_properties
  import fpm_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RESETN,
  input wire logic I_CE,
  input wire logic I_MIDI_IN_ACT,
  input wire logic I_MIDI_OUT_ACT,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic [2:0] O_SCREEN,
  input wire logic [1:0] O_PAGE,
  input wire logic [2:0] O_LINE,
  input wire logic O_VERT_MODE,
  input wire logic O_VOL_PHONES,
  input wire logic [7:0] O_TITLE_CHAN,
  input wire logic O_MIDI_IN_LED,
  input wire logic O_MIDI_OUT_LED,
  input wire logic O_ACTION_STB,
  input wire logic [4:0] O_ACTION,
  input wire logic O_ADJ_STB
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESETN);

  // ==========================================
  // bus answer
  property p_ready_wait;
    I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("no answer after access phase");
  property p_ready_pulse;
    O_PREADY |=> !O_PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_refuse_ro;
    I_PSEL && I_PENABLE && !O_PREADY && I_PWRITE && I_PADDR == ADDR_STATUS
      |=> O_PREADY && O_PSLVERR;
  endproperty
  a_refuse_ro: assert property (p_refuse_ro) else $error("status write not refused");

  // ==========================================
  // panel behaviour
  property p_screen;
    O_SCREEN <= SCR_KEYMENU;
  endproperty
  a_screen: assert property (p_screen) else $error("screen code out of range");
  property p_title;
    O_VOL_PHONES && $past(O_VOL_PHONES) |-> O_TITLE_CHAN == PHONES_CHAN;
  endproperty
  a_title: assert property (p_title) else $error("title not showing phones pair");
  property p_open;
    $rose(O_SCREEN == SCR_OPTIONS)
      |-> ##[0:1] (O_LINE == CURSOR_LINE_OPEN && !O_VERT_MODE && O_PAGE == 2'h0);
  endproperty
  a_open: assert property (p_open) else $error("options opened in wrong place");
  property p_page_step;
    $changed(O_PAGE) && O_SCREEN == SCR_OPTIONS && $stable(O_SCREEN)
      |-> O_PAGE == $past(O_PAGE) + 2'h1 || O_PAGE == $past(O_PAGE) - 2'h1;
  endproperty
  a_page_step: assert property (p_page_step) else $error("page skipped");
  property p_adj_pulse;
    O_ADJ_STB |=> !O_ADJ_STB;
  endproperty
  a_adj_pulse: assert property (p_adj_pulse) else $error("adjust strobe too long");
  property p_act_pulse;
    O_ACTION_STB |=> !O_ACTION_STB;
  endproperty
  a_act_pulse: assert property (p_act_pulse) else $error("action strobe too long");
  property p_act_code;
    O_ACTION_STB |-> O_ACTION < 5'h11;
  endproperty
  a_act_code: assert property (p_act_code) else $error("action code out of range");
  property p_midi;
    I_RESETN && I_CE |=> O_MIDI_IN_LED == $past(I_MIDI_IN_ACT) &&
      O_MIDI_OUT_LED == $past(I_MIDI_OUT_ACT);
  endproperty
  a_midi: assert property (p_midi) else $error("activity led does not follow");

  c_options: cover property ($rose(O_SCREEN == SCR_OPTIONS));
  c_analog: cover property ($rose(O_SCREEN == SCR_ANALOG));
  c_action: cover property (O_ACTION_STB);
endmodule

bind fpm_front_panel fpm_front_panel_properties u_fpm_front_panel_properties (
  .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_CE(I_CE), .I_MIDI_IN_ACT(I_MIDI_IN_ACT),
  .I_MIDI_OUT_ACT(I_MIDI_OUT_ACT), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .O_SCREEN(O_SCREEN), .O_PAGE(O_PAGE), .O_LINE(O_LINE), .O_VERT_MODE(O_VERT_MODE),
  .O_VOL_PHONES(O_VOL_PHONES), .O_TITLE_CHAN(O_TITLE_CHAN), .O_MIDI_IN_LED(O_MIDI_IN_LED),
  .O_MIDI_OUT_LED(O_MIDI_OUT_LED), .O_ACTION_STB(O_ACTION_STB), .O_ACTION(O_ACTION),
  .O_ADJ_STB(O_ADJ_STB)
);

/* File: tb/tb.sv */
// self-checking bench for the front panel controller
`timescale 1ns/1ps
module tb;
  import fpm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic midi_in = 1'b0;
  logic midi_out = 1'b0;
  logic ce = 1'b1;
  logic led_in, led_out, adj_stb, adj_up, got_adj_up;
  int n_adj = 0;
  logic [3:0] key;
  logic push, enc_a, enc_b, pready, pslverr, vert, phones, scope, act_stb;
  logic [31:0] prdata;
  logic [2:0] screen, line;
  logic [1:0] page;
  logic [7:0] volume, title;
  logic [4:0] act, got_act;
  int num_errors = 0;
  int n_checks = 0;
  int n_act = 0;

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    midi_in <= ~midi_out;
    midi_out <= midi_in;
    if (act_stb === 1'b1) begin
      got_act <= act;
      n_act <= n_act + 1;
    end
    if (adj_stb === 1'b1) begin
      got_adj_up <= adj_up;
      n_adj <= n_adj + 1;
    end
  end

  fpm_front_panel #(.TICK_CYC(2), .IDLE_T(50), .DEB_T(1)) u_fpm_front_panel (
    .I_MCLK(clk), .I_RESETN(rst_n), .I_CE(ce), .I_KEY(key), .I_KNOB_PUSH(push),
    .I_ENC_A(enc_a), .I_ENC_B(enc_b), .I_MIDI_IN_ACT(midi_in), .I_MIDI_OUT_ACT(midi_out),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_SCREEN(screen), .O_PAGE(page), .O_LINE(line), .O_VERT_MODE(vert),
    .O_VOL_PHONES(phones), .O_VOLUME(volume), .O_TITLE_CHAN(title), .O_SCOPE_MAIN(scope),
    .O_MIDI_IN_LED(led_in), .O_MIDI_OUT_LED(led_out), .O_ACTION_STB(act_stb), .O_ACTION(act),
    .O_ADJ_STB(adj_stb), .O_ADJ_UP(adj_up)
  );
  fpm_operator u_fpm_operator (
    .i_clk(clk), .o_key(key), .o_push(push), .o_enc_a(enc_a), .o_enc_b(enc_b)
  );

  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic e_err, input logic [31:0] e_rd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(32'(pready), 32'h1);
    chk(32'(pslverr), 32'(e_err));
    if (!wr && !e_err) chk(prdata, e_rd);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_scr(input logic [2:0] e);
    int n;
    n = 0;
    while (screen !== e && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(screen), 32'(e));
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ==========================================
  // scenarios
  task automatic s_reset;
    logic [1:0] v;
    chk(32'(screen), 32'(SCR_GLOBAL));
    @(posedge clk);
    v = {midi_out, midi_in};
    @(posedge clk);
    chk(32'({led_out, led_in}), 32'(v));
    chk(32'(title), 32'(MAIN_CHAN_DEF));
    chk(32'(volume), 32'(VOL_DEF));
    apb(1'b0, ADDR_CTRL, 32'h0, 1'b0, CTRL_RESET);
    apb(1'b0, 12'h020, 32'h0, 1'b1, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'hffff_ffff, 1'b1, 32'h0);
  endtask
  task automatic s_volume;
    u_fpm_operator.press(4, 20);
    chk(32'(phones), 32'h1);
    chk(32'(title), 32'(PHONES_CHAN));
    apb(1'b0, ADDR_STATUS, 32'h0, 1'b0, 32'h0000_0040);
    u_fpm_operator.press(4, 20);
    chk(32'(phones), 32'h0);
    @(posedge clk);
    ce <= 1'b0;
    u_fpm_operator.press(4, 20);
    ce <= 1'b1;
    idle(12);
    chk(32'(phones), 32'h0);
  endtask
  task automatic s_meter;
    u_fpm_operator.press(4, 1100);
    wait_scr(SCR_ANALOG);
    u_fpm_operator.turn(1'b1);
    wait_scr(SCR_VOLUME);
    chk(32'(volume), 32'h1);
  endtask
  task automatic s_menu;
    u_fpm_operator.press(3, 20);
    wait_scr(SCR_OPTIONS);
    chk(32'(line), 32'(CURSOR_LINE_OPEN));
    chk(32'(vert), 32'h0);
    for (int i = 1; i < 5; i++) begin
      u_fpm_operator.turn(1'b1);
      chk(32'(page), i % 4);
    end
    u_fpm_operator.press(4, 20);
    chk(32'(vert), 32'h1);
    u_fpm_operator.press(4, 20);
    chk(32'(vert), 32'h0);
    u_fpm_operator.press(3, 20);
    wait_scr(SCR_GLOBAL);
    u_fpm_operator.press(3, 20);
    wait_scr(SCR_OPTIONS);
    idle(70);
    chk(32'(screen), 32'(SCR_OPTIONS));
    wait_scr(SCR_GLOBAL);
  endtask
  task automatic s_remap;
    apb(1'b1, ADDR_CTRL, 32'h0000_1204, 1'b0, 32'h0);
    for (int a = 0; a < 17; a++) begin
      apb(1'b1, ADDR_REMAP, 32'(a), 1'b0, 32'h0);
      u_fpm_operator.press(0, 20);
      chk(32'(got_act), a);
    end
    chk(n_act, 17);
    apb(1'b0, ADDR_ACTION, 32'h0, 1'b0, 32'h10);
    u_fpm_operator.press(0, 1030);
    wait_scr(SCR_KEYMENU);
    chk(n_act, 17);
    wait_scr(SCR_GLOBAL);
    apb(1'b1, ADDR_CTRL, CTRL_RESET, 1'b0, 32'h0);
  endtask
  task automatic s_lock;
    for (int l = 1; l < 3; l++) begin
      apb(1'b1, ADDR_CTRL, 32'h0000_1200 | l, 1'b0, 32'h0);
      u_fpm_operator.press(3, 20);
      u_fpm_operator.press(4, 20);
      chk(32'(screen), 32'(SCR_GLOBAL));
      chk(32'(phones), 32'h1);
      u_fpm_operator.press(3, 4200);
      apb(1'b0, ADDR_CTRL, 32'h0, 1'b0, CTRL_RESET);
    end
  endtask
  task automatic s_scope_sense;
    apb(1'b1, ADDR_CTRL, 32'h0000_1208, 1'b0, 32'h0);
    idle(2);
    chk(32'(scope), 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h0000_1210, 1'b0, 32'h0);
    idle(2);
    chk(32'(scope), 32'h0);
    u_fpm_operator.press(3, 20);
    wait_scr(SCR_OPTIONS);
    u_fpm_operator.turn(1'b1);
    chk(32'(page), 32'h3);
    u_fpm_operator.press(4, 20);
    u_fpm_operator.turn(1'b1);
    chk(32'(line), 32'h2);
    u_fpm_operator.press(4, 20);
    u_fpm_operator.turn(1'b1);
    chk(n_adj, 1);
    chk(32'(got_adj_up), 32'h0);
    u_fpm_operator.press(3, 20);
    wait_scr(SCR_GLOBAL);
  endtask

  // ==========================================
  // run control
  task automatic stop_test;
    $display("errors=%0d checks=%0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    s_reset();
    s_volume();
    s_meter();
    s_menu();
    s_remap();
    s_lock();
    s_scope_sense();
    stop_test();
  end
endmodule
